/* design/kms_map.vh */
/*
  constants for the keypad matrix scanner: matrix size, code field positions, queue depth.
  assumes plain verilog-2005 and inclusion by bare name.
*/
`ifndef KMS_MAP_VH
`define KMS_MAP_VH
`define KMS_NUM_COLS 4
`define KMS_NUM_ROWS 5
`define KMS_COL_W 2
`define KMS_CODE_W 8
`define KMS_CODE_PRESS_BIT 7
`define KMS_CODE_COL_HI 6
`define KMS_CODE_COL_LO 4
`define KMS_CODE_ZERO_BIT 3
`define KMS_CODE_ROW_HI 2
`define KMS_CODE_ROW_LO 0
`define KMS_QUEUE_DEPTH 32
`define KMS_QUEUE_AW 5
`define KMS_QUEUE_FULL 6'h20
`define KMS_KEYS_RST 20'h00000
`define KMS_COL_RST 2'h0
`endif

/* design/kms_code_queue.v */
/*
  small circular queue of pending key codes, one pushed word at a time.
  assumes the writer never pushes into a full queue; depth covers every key changing.
*/
`default_nettype none
`include "kms_map.vh"
module kms_code_queue (
  // clock and reset
  input wire clk,
  input wire reset,
  // fill side
  input wire push,
  input wire [`KMS_CODE_W-1:0] push_code,
  // drain side
  input wire pop,
  output wire [`KMS_CODE_W-1:0] head_code,
  output wire not_empty,
  output wire [`KMS_QUEUE_AW:0] used_count
);
  reg [`KMS_CODE_W-1:0] mem [0:`KMS_QUEUE_DEPTH-1];
  reg [`KMS_QUEUE_AW-1:0] wr_ptr_q;
  reg [`KMS_QUEUE_AW-1:0] rd_ptr_q;
  reg [`KMS_QUEUE_AW:0] count_q;
  wire do_pop;
  assign do_pop = pop && (count_q != {(`KMS_QUEUE_AW+1){1'b0}});
  assign head_code = mem[rd_ptr_q];
  assign not_empty = (count_q != {(`KMS_QUEUE_AW+1){1'b0}});
  assign used_count = count_q;
  always @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_q] <= push_code;
    end
  end
  always @(posedge clk) begin
    if (reset) begin
      wr_ptr_q <= {`KMS_QUEUE_AW{1'b0}};
      rd_ptr_q <= {`KMS_QUEUE_AW{1'b0}};
      count_q <= {(`KMS_QUEUE_AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (do_pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
      if (push && !do_pop) begin
        count_q <= count_q + 1'b1;
      end else if (do_pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end
endmodule // kms_code_queue
`default_nettype wire

/* design/kms_scanner.v */
/*
  keypad matrix scanner: rotates one active column drive, samples five row lines, queues
  press and release codes and issues one code per scan tick with a one-tick strobe.
  assumes a passive switch matrix; row and scan inputs arrive asynchronously from pins.
*/
// How it works
// - matrix has up to four columns and five rows, twenty keys.
// - each scan tick moves the active column drive to the next column.
// - during a column, all five rows are sampled; high row means pressed key.
// - new-code strobe is high for exactly one scan tick per new code.
// - with report release set, codes are made on press and on release.
// - with report release clear, codes are made on press only.
// - code is press bit 7, column bits 6..4, zero bit 3, row bits 2..0.
// - several keys in one column resolve; across columns only with diodes.
// - several changes in one column are queued and sent one per tick.
`default_nettype none
`include "kms_map.vh"
module kms_scanner (
  // clock and reset
  input wire clk,
  input wire reset,
  // control
  input wire scan_enable,
  input wire report_release,
  // matrix pins
  input wire [`KMS_NUM_ROWS-1:0] row_sense_in,
  output reg [`KMS_NUM_COLS-1:0] column_drive_out,
  // key code output
  output reg [`KMS_CODE_W-1:0] key_code,
  output reg new_event_strobe
);
  reg [`KMS_NUM_ROWS-1:0] row_meta_q;
  reg [`KMS_NUM_ROWS-1:0] row_sync_q;
  reg en_meta_q;
  reg en_sync_q;
  reg rel_meta_q;
  reg rel_sync_q;
  reg [`KMS_COL_W-1:0] col_q;
  reg [`KMS_COL_W-1:0] col_d;
  reg [`KMS_NUM_COLS*`KMS_NUM_ROWS-1:0] keys_q;
  reg [`KMS_NUM_ROWS-1:0] pend_q;
  reg [`KMS_NUM_ROWS-1:0] pend_d;
  reg [`KMS_COL_W-1:0] pend_col_q;
  reg [`KMS_NUM_ROWS-1:0] pend_state_q;
  reg push;
  reg [`KMS_CODE_W-1:0] push_code;
  wire [`KMS_CODE_W-1:0] head_code;
  wire not_empty;
  wire [`KMS_QUEUE_AW:0] used_count;
  wire [`KMS_NUM_ROWS-1:0] old_col;
  wire [`KMS_NUM_ROWS-1:0] changed;

  // row selection for the queue
  wire [`KMS_NUM_ROWS-1:0] wanted;
  wire [`KMS_NUM_ROWS-1:0] grant;
  wire [`KMS_NUM_ROWS:0] taken;

  // queue guard and scan tick
  wire queue_full;
  wire push_ok;
  wire tick;
  integer i;
  genvar g;

  // one-hot column drive from a column number
  function [`KMS_NUM_COLS-1:0] col_onehot;
    input [`KMS_COL_W-1:0] c;
    begin
      case (c)
        2'h0: col_onehot = 4'h1;
        2'h1: col_onehot = 4'h2;
        2'h2: col_onehot = 4'h4;
        2'h3: col_onehot = 4'h8;
        default: col_onehot = 4'h1;
      endcase
    end
  endfunction

  // key code layout
  function [`KMS_CODE_W-1:0] make_code;
    input pressed;
    input [`KMS_COL_W-1:0] c;
    input [2:0] r;
    begin
      make_code = {`KMS_CODE_W{1'b0}};
      make_code[`KMS_CODE_PRESS_BIT] = pressed;
      make_code[`KMS_CODE_COL_HI:`KMS_CODE_COL_LO] = {1'b0, c};
      make_code[`KMS_CODE_ZERO_BIT] = 1'b0;
      make_code[`KMS_CODE_ROW_HI:`KMS_CODE_ROW_LO] = r;
    end
  endfunction

  // row lines and controls come from pins, so two flops before use
  always @(posedge clk) begin
    row_meta_q <= row_sense_in;
    row_sync_q <= row_meta_q;
  end

  always @(posedge clk) begin
    en_meta_q <= scan_enable;
    en_sync_q <= en_meta_q;
  end

  always @(posedge clk) begin
    rel_meta_q <= report_release;
    rel_sync_q <= rel_meta_q;
  end

  // a scan tick is the synchronised enable; hold it as single-clock pulses
  assign tick = en_sync_q;

  // rows are read two clocks after the drive moves; a scan tick must therefore be
  // spaced at least three clocks apart so synchronised rows belong to the driven column
  assign old_col = keys_q[col_q*`KMS_NUM_ROWS +: `KMS_NUM_ROWS];
  assign changed = old_col ^ row_sync_q;

  always @* begin
    col_d = col_q + 1'b1;
  end

  // a pending row earns a code if it is a press or releases are reported
  assign taken[0] = 1'b0;
  generate
    for (g = 0; g < `KMS_NUM_ROWS; g = g + 1) begin : g_pick
      assign wanted[g] = pend_q[g] && (pend_state_q[g] || rel_sync_q);
      assign grant[g] = wanted[g] && !taken[g];
      assign taken[g + 1] = taken[g] || wanted[g];
    end
  endgenerate

  // one granted row per clock goes to the queue, lowest row first; unreported
  // releases are dropped at once so the code always matches the granted row
  always @* begin
    push = |grant;
    push_code = {`KMS_CODE_W{1'b0}};
    pend_d = wanted & ~grant;
    for (i = 0; i < `KMS_NUM_ROWS; i = i + 1) begin
      if (grant[i]) begin
        push_code = make_code(pend_state_q[i], pend_col_q, i[2:0]);
      end
    end
  end

  // column pointer and its one-hot drive move only on a scan tick
  always @(posedge clk) begin
    if (reset) begin
      col_q <= `KMS_COL_RST;
      column_drive_out <= col_onehot(`KMS_COL_RST);
    end else if (tick) begin
      col_q <= col_d;
      column_drive_out <= col_onehot(col_d);
    end
  end

  // stored key states; without diodes, keys in other columns may ghost here
  always @(posedge clk) begin
    if (reset) begin
      keys_q <= `KMS_KEYS_RST;
    end else if (tick) begin
      keys_q[col_q*`KMS_NUM_ROWS +: `KMS_NUM_ROWS] <= row_sync_q;
    end
  end

  // pending change bits of the last sampled column
  always @(posedge clk) begin
    if (reset) begin
      pend_q <= {`KMS_NUM_ROWS{1'b0}};
    end else if (tick) begin
      pend_q <= pend_d | changed;
    end else begin
      pend_q <= pend_d;
    end
  end

  // column and row states that the pending bits refer to
  always @(posedge clk) begin
    if (reset) begin
      pend_col_q <= `KMS_COL_RST;
      pend_state_q <= {`KMS_NUM_ROWS{1'b0}};
    end else if (tick) begin
      pend_col_q <= col_q;
      pend_state_q <= row_sync_q;
    end
  end

  // the oldest queued code goes out on a tick, strobed for one clock
  always @(posedge clk) begin
    if (reset) begin
      key_code <= {`KMS_CODE_W{1'b0}};
      new_event_strobe <= 1'b0;
    end else begin
      new_event_strobe <= 1'b0;
      if (tick && not_empty) begin
        key_code <= head_code;
        new_event_strobe <= 1'b1;
      end
    end
  end

  // when a tick lands while old changes are still being pushed, their pending rows stay but
  // take the new column and states; ticks must leave five clocks to drain the pending rows
  // a full queue refuses the word rather than wrap over the oldest code
  assign queue_full = (used_count == `KMS_QUEUE_FULL);
  assign push_ok = push && !queue_full;

  kms_code_queue u_queue (
    .clk(clk),
    .reset(reset),
    .push(push_ok),
    .push_code(push_code),
    .pop(tick),
    .head_code(head_code),
    .not_empty(not_empty),
    .used_count(used_count)
  );
endmodule // kms_scanner
`default_nettype wire

/* bench/kms_scanner_properties.sv */
/* port assertions for the keypad scanner.
   assumes single-clock scan pulses at least six clocks apart. */
`default_nettype none
module kms_scanner_properties (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // control and matrix pins
  input wire logic scan_enable,
  input wire logic report_release,
  input wire logic [4:0] row_sense_in,
  input wire logic [3:0] column_drive_out,
  // code output
  input wire logic [7:0] key_code,
  input wire logic new_event_strobe
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic [3:0] col_prev_q;
  always_ff @(posedge clk) col_prev_q <= column_drive_out;
  // two sync flops plus the column drive register put the move three clocks late
  sequence s_moved;
    ##3 (column_drive_out == {col_prev_q[2:0], col_prev_q[3]});
  endsequence
  sequence s_quiet;
    !new_event_strobe [*5];
  endsequence
  a_col_onehot: assert property ($onehot(column_drive_out))
    else $error("column drive not one-hot");
  a_tick_rotates: assert property (scan_enable |-> s_moved)
    else $error("column did not rotate on tick");
  a_col_only_tick: assert property ($changed(column_drive_out) |-> $past(scan_enable, 3))
    else $error("column moved without tick");
  a_strobe_on_tick: assert property (new_event_strobe |-> $past(scan_enable, 3))
    else $error("strobe outside tick");
  a_strobe_single: assert property (new_event_strobe |=> s_quiet)
    else $error("strobe longer than one tick");
  a_code_holds: assert property (!new_event_strobe |-> $stable(key_code))
    else $error("code changed without strobe");
  a_code_fields: assert property (new_event_strobe |->
    !key_code[3] && key_code[6:4] < 3'h4 && key_code[2:0] < 3'h5)
    else $error("bad code field");
  a_release_gated: assert property (new_event_strobe && !key_code[7] |->
    $past(report_release, 4))
    else $error("release code while releases off");
endmodule // kms_scanner_properties
bind kms_scanner kms_scanner_properties kms_scanner_properties_inst (.clk(clk),
  .reset(reset), .scan_enable(scan_enable), .report_release(report_release),
  .row_sense_in(row_sense_in), .column_drive_out(column_drive_out),
  .key_code(key_code), .new_event_strobe(new_event_strobe));
`default_nettype wire

/* bench/kms_key_matrix.sv */
/* passive key matrix with one isolation diode per key.
   assumes key index is column times five plus row. */
`default_nettype none
module kms_key_matrix (
  // column drive and key states
  input wire logic [3:0] column_drive_out,
  input wire logic [19:0] keys_down,
  // row lines, pulled low when open
  output logic [4:0] row_sense_in
);
  // diodes keep undriven columns off the rows
  always_comb begin
    row_sense_in = 5'h00;
    for (int c = 0; c < 4; c++)
      if (column_drive_out[c]) row_sense_in |= keys_down[c*5 +: 5];
  end
endmodule // kms_key_matrix
`default_nettype wire

/* bench/kms_scanner_bench.sv */
/* bench for the keypad scanner: scan pulses, keys through the matrix model.
   assumes the checker is bound to the scanner. */
`default_nettype none
module kms_scanner_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic scan_enable = 1'b0;
  logic report_release = 1'b1;
  logic [19:0] keys_down = 20'h00000;
  wire logic [4:0] rows;
  wire logic [3:0] cols;
  wire logic [7:0] key_code;
  wire logic strobe;
  logic [7:0] got[$];
  int bad_count = 0;
  int cmp_count = 0;
  always #12.5 clk = ~clk;
  kms_scanner kms_scanner_inst (.clk(clk), .reset(reset), .scan_enable(scan_enable),
    .report_release(report_release), .row_sense_in(rows), .column_drive_out(cols),
    .key_code(key_code), .new_event_strobe(strobe));
  kms_key_matrix kms_key_matrix_inst (.column_drive_out(cols), .keys_down(keys_down),
    .row_sense_in(rows));
  always @(negedge clk) if (strobe === 1'b1) got.push_back(key_code);
  task automatic chk(input logic [7:0] exp, input logic [7:0] act);
    cmp_count++;
    if (act !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, act, exp);
    end
  endtask
  // pulses eight clocks apart: sync delay plus draining leave margin
  task automatic ticks(input int n);
    repeat (n) begin
      @(negedge clk) scan_enable = 1'b1;
      @(negedge clk) scan_enable = 1'b0;
      repeat (6) @(negedge clk);
    end
  endtask
  task automatic expect_run(input logic [7:0] first, input int n);
    chk(8'(n), 8'(got.size()));
    for (int i = 0; i < n; i++)
      chk(first + 8'(i), i < got.size() ? got[i] : 8'hXX);
    got.delete();
  endtask
  task automatic t_after_reset;
    chk(8'h01, {4'h0, cols});
    chk(8'h00, key_code);
    chk(8'h00, {7'h00, strobe});
  endtask
  task automatic t_rotate;
    for (int i = 1; i <= 4; i++) begin
      ticks(1);
      chk(8'h01 << (i % 4), {4'h0, cols});
    end
    expect_run(8'h00, 0);
  endtask
  task automatic t_column_burst;
    keys_down[9:5] = 5'h1F;
    ticks(12);
    expect_run(8'h90, 5);
    keys_down[9:5] = 5'h00;
    ticks(12);
    expect_run(8'h10, 5);
  endtask
  task automatic t_press_only;
    report_release = 1'b0;
    ticks(2);
    keys_down[19] = 1'b1;
    ticks(8);
    expect_run(8'hB4, 1);
    keys_down[19] = 1'b0;
    ticks(8);
    expect_run(8'h00, 0);
  endtask
  task automatic t_reset_mid;
    report_release = 1'b1;
    keys_down[4:0] = 5'h1F;
    ticks(3);
    reset = 1'b1;
    repeat (3) @(negedge clk);
    reset = 1'b0;
    got.delete();
    t_after_reset;
    ticks(12);
    expect_run(8'h80, 5);
  endtask
  task automatic results;
    if (bad_count == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge clk);
    reset = 1'b0;
    t_after_reset;
    t_rotate;
    t_column_burst;
    t_press_only;
    t_reset_mid;
    results;
  end
endmodule // kms_scanner_bench
`default_nettype wire
